// *** rtl/bsr_consts.svh ***
`ifndef BSR_CONSTS_SVH
`define BSR_CONSTS_SVH
// Data and address widths
`define BSR_DW 18
`define BSR_AW 4
`define BSR_BL 2
`define BSR_DEPTH 16
// Byte lane split point
`define BSR_LANE_LSB 9
`define BSR_WORD_RST 18'h00000
`endif

// *** rtl/bsr_pkg.sv ***
package bsr_pkg;
   typedef enum logic [1:0] {
      BSR_IDLE,
      BSR_RD2,
      BSR_WR1,
      BSR_WR2
   } bsr_state_t;
endpackage

// *** rtl/bsr_fifo.sv ***
`timescale 1ns/1ps
module bsr_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 16
) (
   input  wire logic             ref_clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [PW:0]      wr_ff;
   logic [PW:0]      rd_ff;
   logic             push;
   logic             pop;

   // Honest full and empty from pointers
   assign in_ready  = (wr_ff - rd_ff) != (PW+1)'(DEPTH);
   assign out_valid = wr_ff != rd_ff;
   assign out_data  = mem_ff[rd_ff[PW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Storage write
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_ff[wr_ff[PW-1:0]] <= in_data;
      end
   end

   // Pointer update
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wr_ff <= '0;
         rd_ff <= '0;
      end else begin
         if (push) begin
            wr_ff <= wr_ff + 1'h1;
         end
         if (pop) begin
            rd_ff <= rd_ff + 1'h1;
         end
      end
   end
endmodule // bsr_fifo

// *** rtl/bsr_sram.sv ***
`timescale 1ns/1ps
`include "bsr_consts.svh"
// Functional notes
// RULE_01 - Load low at input clock rise: select high reads, low writes.
// RULE_02 - Read words are driven on output clock pair edges.
// RULE_03 - Inputs captured on positive input clock rise; accesses start there.
// RULE_04 - Write data also captured on negative input clock rise.
// RULE_05 - Single clock mode drives read data on input clock edges.
// RULE_06 - Positive echo clock follows positive output or input clock.
// RULE_07 - Negative echo clock follows negative output or input clock.
// RULE_08 - Strap at ground disables loop; output timing becomes unlocked.
// RULE_09 - Each load defines one cycle of a two-word burst.
// RULE_10 - Read: first word after next input rise, second on next output edge.
// RULE_11 - Write: first word at next positive rise, second at negative rise.
// RULE_12 - Deasserted byte lane select keeps that stored byte unchanged.
module bsr_sram (
   input  wire logic                ref_clk,
   input  wire logic                reset,
   input  wire logic                in_clk_p,
   input  wire logic                in_clk_n,
   input  wire logic                out_clk_p,
   input  wire logic                out_clk_n,
   input  wire logic                single_clock_mode,
   input  wire logic                loop_disable_strap,
   input  wire logic                cycle_load_strobe_n,
   input  wire logic                read_not_write,
   input  wire logic [`BSR_AW-1:0]  addr,
   input  wire logic [`BSR_DW-1:0]  wr_data,
   input  wire logic [1:0]          byte_lane_select_n,
   output logic      [`BSR_DW-1:0]  rd_data,
   output logic                     rd_valid,
   output logic                     read_echo_clock_p,
   output logic                     read_echo_clock_n,
   output logic                     loop_locked
);
   // Two-flop synchronisers for all pins, mode strap included
   localparam int NS = 8 + `BSR_AW + `BSR_DW + 2;
   logic [NS-1:0] s1_ff;
   logic [NS-1:0] s2_ff;
   logic [3:0]    s3_ff;
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end else begin
         s1_ff <= {in_clk_p, in_clk_n, out_clk_p, out_clk_n, cycle_load_strobe_n,
                   read_not_write, addr, wr_data, byte_lane_select_n, loop_disable_strap,
                   single_clock_mode};
         s2_ff <= s1_ff;
         s3_ff <= s2_ff[NS-1:NS-4]; // Only the four clocks need a previous sample
      end
   end

   logic                 kp, kn, cp, cn, ld_n, rnw, strap, smode;
   logic [`BSR_AW-1:0]   a_s;
   logic [`BSR_DW-1:0]   d_s;
   logic [1:0]           be_n;
   assign {kp, kn, cp, cn, ld_n, rnw, a_s, d_s, be_n, strap, smode} = s2_ff;

   // Rising edge detection on synchronised clocks
   logic kp_rise, kn_rise, cp_rise, cn_rise, op_rise, on_rise;
   assign kp_rise = kp && !s3_ff[3];
   assign kn_rise = kn && !s3_ff[2];
   assign cp_rise = cp && !s3_ff[1];
   assign cn_rise = cn && !s3_ff[0];
   assign op_rise = smode ? kp_rise : cp_rise; // RULE_02 RULE_05
   assign on_rise = smode ? kn_rise : cn_rise; // RULE_02 RULE_05

   // Byte lane merge function
   function automatic logic [`BSR_DW-1:0] merge(input logic [`BSR_DW-1:0] old,
                                                input logic [`BSR_DW-1:0] nw,
                                                input logic [1:0] sel_n);
      logic [`BSR_DW-1:0] r;
      r = old;
      if (!sel_n[0]) r[`BSR_LANE_LSB-1:0] = nw[`BSR_LANE_LSB-1:0];
      if (!sel_n[1]) r[`BSR_DW-1:`BSR_LANE_LSB] = nw[`BSR_DW-1:`BSR_LANE_LSB];
      return r;
   endfunction

   // Memory array, two words per address
   logic [`BSR_DW-1:0] mem_ff [`BSR_DEPTH*`BSR_BL];
   bsr_pkg::bsr_state_t st_ff;
   logic [`BSR_AW-1:0] adr_ff;
   logic               rd_pend_ff;
   logic [`BSR_DW-1:0] fifo_in;
   logic               fifo_push;
   logic               fifo_ready;
   logic               wsel_ff;
   logic               rd_go_ff;

   // Access sequencer
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st_ff  <= bsr_pkg::BSR_IDLE;
         adr_ff <= '0;
      end else begin
         case (st_ff)
            bsr_pkg::BSR_IDLE: begin
               if (kp_rise && !ld_n) begin // RULE_01 RULE_03 RULE_09
                  adr_ff <= a_s;
                  st_ff  <= rnw ? bsr_pkg::BSR_RD2 : bsr_pkg::BSR_WR1;
               end
            end
            bsr_pkg::BSR_RD2: begin
               if (fifo_push && fifo_ready && wsel_ff) begin // RULE_09 RULE_10
                  st_ff <= bsr_pkg::BSR_IDLE;
               end
            end
            bsr_pkg::BSR_WR1: begin
               if (kp_rise) begin // RULE_11
                  st_ff <= bsr_pkg::BSR_WR2;
               end
            end
            bsr_pkg::BSR_WR2: begin
               if (kn_rise) begin // RULE_04 RULE_11
                  st_ff <= bsr_pkg::BSR_IDLE;
               end
            end
            default: st_ff <= bsr_pkg::BSR_IDLE;
         endcase
      end
   end

   // Write path with byte lanes
   always_ff @(posedge ref_clk) begin
      if (st_ff == bsr_pkg::BSR_WR1 && kp_rise) begin
         mem_ff[{adr_ff, 1'h0}] <= merge(mem_ff[{adr_ff, 1'h0}], d_s, be_n); // RULE_12
      end
      if (st_ff == bsr_pkg::BSR_WR2 && kn_rise) begin
         mem_ff[{adr_ff, 1'h1}] <= merge(mem_ff[{adr_ff, 1'h1}], d_s, be_n); // RULE_12
      end
   end

   // Read burst into FIFO, one word per pending step
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wsel_ff <= 1'h0;
      end else if (fifo_push && fifo_ready) begin
         wsel_ff <= !wsel_ff; // RULE_10
      end
   end

   // Read words wait for the input clock rise after the load
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rd_go_ff <= 1'h0;
      end else if (st_ff != bsr_pkg::BSR_RD2) begin
         rd_go_ff <= 1'h0;
      end else if (kp_rise) begin
         rd_go_ff <= 1'h1; // RULE_10
      end
   end
   assign fifo_push = (st_ff == bsr_pkg::BSR_RD2) && rd_go_ff;
   assign fifo_in   = mem_ff[{adr_ff, wsel_ff}];

   logic [`BSR_DW-1:0] f_data;
   logic               f_valid;
   logic               f_pop;
   bsr_fifo #(.WIDTH(`BSR_DW), .DEPTH(`BSR_DEPTH)) u_fifo (
      .ref_clk   (ref_clk),
      .reset     (reset),
      .in_data   (fifo_in),
      .in_valid  (fifo_push),
      .in_ready  (fifo_ready),
      .out_data  (f_data),
      .out_valid (f_valid),
      .out_ready (f_pop)
   );

   // Drain one word per output clock edge, input clock edge in single clock mode; first on negative edge
   logic half_ff;
   assign f_pop = f_valid && (half_ff ? op_rise : on_rise); // RULE_10
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rd_data  <= `BSR_WORD_RST;
         rd_valid <= 1'h0;
         half_ff  <= 1'h0;
      end else begin
         if (f_pop) begin
            rd_data  <= f_data; // RULE_02
            rd_valid <= 1'h1;
            half_ff  <= !half_ff;
         end else if (op_rise || on_rise) begin
            rd_valid <= 1'h0;
         end
      end
   end

   // Echo sources: output clocks, or input clocks in single clock mode
   logic echo_src_p;
   logic echo_src_n;
   assign echo_src_p = smode ? kp : cp; // RULE_06
   assign echo_src_n = smode ? kn : cn; // RULE_07

   // Free-running echo clocks
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         read_echo_clock_p <= 1'h0;
         read_echo_clock_n <= 1'h0;
         loop_locked       <= 1'h0;
      end else begin
         read_echo_clock_p <= echo_src_p; // RULE_06
         read_echo_clock_n <= echo_src_n; // RULE_07
         loop_locked       <= strap; // RULE_08
      end
   end

   // Load taken in idle at an input clock rise, and the two write steps
   sequence s_load(logic dir);
      st_ff == bsr_pkg::BSR_IDLE && kp_rise && !ld_n && rnw == dir;
   endsequence
   sequence s_wr_first;
      st_ff == bsr_pkg::BSR_WR1 && kp_rise;
   endsequence
   sequence s_wr_second;
      st_ff == bsr_pkg::BSR_WR2 && kn_rise;
   endsequence

   // Access sequencing checks
   property p_load_read;
      @(posedge ref_clk) disable iff (reset) s_load(1'h1) |=> st_ff == bsr_pkg::BSR_RD2;
   endproperty
   property p_load_write;
      @(posedge ref_clk) disable iff (reset) s_load(1'h0) |=> st_ff == bsr_pkg::BSR_WR1;
   endproperty
   property p_wr2;
      @(posedge ref_clk) disable iff (reset) s_wr_first |=> st_ff == bsr_pkg::BSR_WR2;
   endproperty
   property p_wr_done;
      @(posedge ref_clk) disable iff (reset) s_wr_second |=> st_ff == bsr_pkg::BSR_IDLE;
   endproperty

   // Output side checks
   property p_echo_p;
      @(posedge ref_clk) disable iff (reset) read_echo_clock_p == $past(echo_src_p);
   endproperty
   property p_echo_n;
      @(posedge ref_clk) disable iff (reset) read_echo_clock_n == $past(echo_src_n);
   endproperty
   property p_lock;
      @(posedge ref_clk) disable iff (reset) !strap |=> !loop_locked;
   endproperty
   property p_out;
      @(posedge ref_clk) disable iff (reset) f_pop |=> rd_valid && rd_data == $past(f_data);
   endproperty

   a_load_read: assert property (p_load_read) else $error("read not started"); // RULE_01
   a_load_write: assert property (p_load_write) else $error("write not started"); // RULE_03
   a_wr2: assert property (p_wr2) else $error("second write word missed"); // RULE_11
   a_wr_done: assert property (p_wr_done) else $error("write not closed"); // RULE_04
   a_echo_p: assert property (p_echo_p) else $error("positive echo wrong"); // RULE_06
   a_echo_n: assert property (p_echo_n) else $error("negative echo wrong"); // RULE_07
   a_lock: assert property (p_lock) else $error("loop locked with strap low"); // RULE_08
   a_out: assert property (p_out) else $error("read word not driven"); // RULE_02
endmodule // bsr_sram

// *** sim/bsr_ctrl_model.sv ***
`timescale 1ns/1ps
// Controller side: free-running input clocks, output clocks held low in single clock mode, two-word bursts
module bsr_ctrl_model (
   input  wire logic        single_clock_mode,
   output logic             in_clk_p,
   output logic             in_clk_n,
   output logic             out_clk_p,
   output logic             out_clk_n,
   output logic             cycle_load_strobe_n,
   output logic             read_not_write,
   output logic [3:0]       addr,
   output logic [17:0]      wr_data,
   output logic [1:0]       byte_lane_select_n
);
   // Input clock pair, 160 ns period, idle request pins
   initial begin
      cycle_load_strobe_n = 1'h1;
      read_not_write = 1'h1;
      addr = 4'h0;
      wr_data = 18'h00000;
      byte_lane_select_n = 2'h3;
      in_clk_p = 1'h0;
      forever begin
         #80 in_clk_p = ~in_clk_p;
      end
   end
   assign in_clk_n = ~in_clk_p;
   // Output clocks lag by board flight time; held low in single clock mode
   assign #20 out_clk_p = in_clk_p & ~single_clock_mode;
   assign #20 out_clk_n = in_clk_n & ~single_clock_mode;
   // One load, then two data words; released address and data lines carry the inverse, byte lane selects return to 2'h3
   task automatic burst(input logic rnw, input logic [3:0] a, input logic [17:0] w0,
                        input logic [17:0] w1, input logic [1:0] s0, input logic [1:0] s1);
      @(posedge in_clk_n);
      cycle_load_strobe_n = 1'h0;
      read_not_write = rnw;
      addr = a;
      @(posedge in_clk_p);
      #40;
      cycle_load_strobe_n = 1'h1;
      addr = ~a;
      wr_data = w0;
      byte_lane_select_n = s0;
      @(posedge in_clk_p);
      #40;
      wr_data = w1;
      byte_lane_select_n = s1;
      @(posedge in_clk_n);
      #40;
      wr_data = ~w1;
      byte_lane_select_n = 2'h3;
   endtask
endmodule // bsr_ctrl_model

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench;
   logic        ref_clk, reset, single_clock_mode, loop_disable_strap;
   logic        in_clk_p, in_clk_n, out_clk_p, out_clk_n, cycle_load_strobe_n;
   logic        read_not_write, rd_valid, read_echo_clock_p, read_echo_clock_n;
   logic        loop_locked;
   logic [3:0]  addr;
   logic [1:0]  byte_lane_select_n;
   logic [17:0] wr_data, rd_data;
   int          bad_count, n_compared, cycle_cnt;
   bsr_sram i_bsr_sram (.*);
   bsr_ctrl_model i_bsr_ctrl_model (.*);
   // Clock and hang guard
   initial begin
      ref_clk = 1'h0;
      forever #4 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycle_cnt++;
      if (cycle_cnt == 6000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input logic [17:0] seen, input logic [17:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // Read burst, both words compared in arrival order
   task automatic rd_burst(input logic [3:0] a, input logic [17:0] e0, input logic [17:0] e1);
      logic [17:0] first;
      int          n;
      for (n = 0; n < 100 && rd_valid === 1'h1; n++) @(negedge ref_clk);
      fork
         i_bsr_ctrl_model.burst(1'h1, a, 18'h00000, 18'h00000, 2'h3, 2'h3);
      join_none
      for (n = 0; n < 200 && rd_valid !== 1'h1; n++) @(negedge ref_clk);
      first = rd_data;
      check(rd_valid, 18'h00001);
      check(first, e0);
      for (n = 0; n < 30 && rd_data === first; n++) @(negedge ref_clk);
      check(rd_data, e1);
      wait fork;
   endtask
   // Echo clocks follow the output clocks, or the input clocks in single mode
   task automatic echo(input logic single);
      if (single) @(posedge in_clk_p); else @(posedge out_clk_p);
      repeat (5) @(negedge ref_clk);
      check(read_echo_clock_p, 18'h00001);
      if (single) @(posedge in_clk_n); else @(posedge out_clk_n);
      repeat (5) @(negedge ref_clk);
      check(read_echo_clock_n, 18'h00001);
      repeat (10) @(negedge ref_clk);
      check(read_echo_clock_n, 18'h00000);
   endtask
   // Four addresses through the output buffer, then a fully masked write
   task automatic t_buffer();
      int          n;
      logic [3:0]  a;
      logic [17:0] w0;
      logic [17:0] w1;
      for (n = 0; n < 4; n++) begin
         a  = 4'hA + 4'(n);
         w0 = 18'h00111 * 18'(n + 1);
         w1 = 18'h3FFFF ^ 18'(n);
         i_bsr_ctrl_model.burst(1'h0, a, w0, w1, 2'h0, 2'h0);
      end
      for (n = 0; n < 4; n++) begin
         a  = 4'hA + 4'(n);
         w0 = 18'h00111 * 18'(n + 1);
         w1 = 18'h3FFFF ^ 18'(n);
         rd_burst(a, w0, w1);
      end
      i_bsr_ctrl_model.burst(1'h0, 4'hA, 18'h00000, 18'h00000, 2'h3, 2'h3);
      rd_burst(4'hA, 18'h00111, 18'h3FFFF);
      repeat (40) @(negedge ref_clk);
      check(rd_valid, 18'h00000);
      check(rd_data, 18'h3FFFF);
      $display("buffer done");
   endtask
   // Main sequence
   initial begin
      reset = 1'h1;
      single_clock_mode = 1'h0;
      loop_disable_strap = 1'h1;
      repeat (5) @(posedge ref_clk);
      #1 reset = 1'h0;
      repeat (10) @(posedge ref_clk);
      i_bsr_ctrl_model.burst(1'h0, 4'h5, 18'h2A5A5, 18'h15A5A, 2'h0, 2'h0);
      rd_burst(4'h5, 18'h2A5A5, 18'h15A5A);
      echo(1'h0);
      $display("write_read done");
      i_bsr_ctrl_model.burst(1'h0, 4'h5, 18'h3FFFF, 18'h00000, 2'h2, 2'h1);
      rd_burst(4'h5, {9'h152, 9'h1FF}, {9'h000, 9'h05A});
      $display("byte_lanes done");
      @(posedge ref_clk);
      #1 single_clock_mode = 1'h1;
      rd_burst(4'h5, {9'h152, 9'h1FF}, {9'h000, 9'h05A});
      echo(1'h1);
      @(posedge ref_clk);
      #1 single_clock_mode = 1'h0;
      $display("single_clock done");
      @(posedge ref_clk);
      #1 loop_disable_strap = 1'h0;
      repeat (8) @(posedge ref_clk);
      #1 check(loop_locked, 18'h00000);
      loop_disable_strap = 1'h1;
      repeat (8) @(posedge ref_clk);
      #1 check(loop_locked, 18'h00001);
      $display("strap done");
      t_buffer();
      tally_and_finish();
   end
endmodule // testbench
